// ===== verilog/osec_pkg.sv
package osec_pkg;
  // channel count and sync latency
  localparam int          NUM_CH        = 5;
  localparam int          SYNC_LATENCY  = 4;
  localparam logic [2:0]  LAT_W_ONE     = 3'h1;
  // lock indicator modes
  typedef enum logic [1:0] {
    OSEC_LD_BOTH  = 2'b00,
    OSEC_LD_FIRST = 2'b01,
    OSEC_LD_SECOND = 2'b10
  } osec_ld_mode_e;
  // register offsets
  localparam logic [3:0]  ADDR_CH_EN    = 4'h0;
  localparam logic [3:0]  ADDR_CFG      = 4'h1;
  localparam logic [3:0]  ADDR_FB_DIV   = 4'h2;
  localparam logic [3:0]  ADDR_STATUS   = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_CLR  = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_EN   = 4'h5;
  // config field positions
  localparam int          CFG_GLOBAL_EN = 0;
  localparam int          CFG_XTAL_EN   = 1;
  localparam int          CFG_DOUBLER   = 2;
  localparam int          CFG_AUTO_SEL  = 3;
  localparam int          CFG_MAN_SEL   = 4;
  localparam int          CFG_LD_LO     = 5;
  // reset values
  localparam logic [31:0] CFG_RST       = 32'h0000_0001;
  localparam logic [4:0]  CH_EN_RST     = 5'h1f;
  localparam logic [17:0] FB_DIV_RST    = 18'h0_000a;
  // interrupt bits: sync done, calibration done, lock lost
  localparam int          IRQ_W         = 3;
endpackage

// ===== verilog/osec_top.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module osec_top #(
  parameter int NUM_CH  = osec_pkg::NUM_CH,
  parameter int CAL_LEN = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // board pins
  input  wire logic              sync_n,
  input  wire logic              global_output_enable_pin,
  input  wire logic              first_loop_locked,
  input  wire logic              second_loop_locked,
  input  wire logic              primary_ref_a_lost,
  input  wire logic              primary_ref_b_lost,
  // channel clocks and outputs
  input  wire logic [NUM_CH-1:0] ch_clk_in,
  output logic [NUM_CH-1:0]      ch_out,
  output logic [NUM_CH-1:0]      ch_out_oe,
  output logic                   lock_indicator_pin,
  // reference routing and calibration
  output logic                   ref_sel_b,
  output logic                   doubler_path_en,
  output logic                   divider_path_en,
  output logic                   first_loop_fb_src_en,
  output logic                   second_loop_ref_src_en,
  output logic                   crystal_osc_en,
  output logic                   vco_cal_busy,
  output logic                   irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] ch_en_ff;
  logic [31:0]       cfg_ff;
  logic [17:0]       fb_div_ff;
  logic [2:0]        sts_ff, irq_en_ff;
  logic              sync_m_ff, sync_s_ff;
  logic [2:0]        lo_cnt_ff, hi_cnt_ff;
  logic              hold_ff;
  logic              cal_req_ff;
  logic [7:0]        cal_cnt_ff;
  logic              sel_b_ff, lock_d_ff;

  // register decode
  wire wr_ch  = reg_wr && reg_addr == osec_pkg::ADDR_CH_EN;
  wire wr_cfg = reg_wr && reg_addr == osec_pkg::ADDR_CFG;
  wire wr_fb  = reg_wr && reg_addr == osec_pkg::ADDR_FB_DIV;
  wire wr_clr = reg_wr && reg_addr == osec_pkg::ADDR_IRQ_CLR;
  wire wr_ien = reg_wr && reg_addr == osec_pkg::ADDR_IRQ_EN;
  wire g_en   = cfg_ff[osec_pkg::CFG_GLOBAL_EN];
  wire [1:0] ld_mode = cfg_ff[osec_pkg::CFG_LD_LO +: 2];

  // sync, calibration and lock event detection
  wire sync_lo_cnt_done = lo_cnt_ff == 3'(osec_pkg::SYNC_LATENCY - 1);
  wire sync_hi_cnt_done = hi_cnt_ff == 3'(osec_pkg::SYNC_LATENCY - 1);
  wire release_ev = hold_ff && sync_s_ff && sync_hi_cnt_done;
  wire cal_start  = cal_req_ff && first_loop_locked;
  wire cal_done   = vco_cal_busy && cal_cnt_ff == 8'(CAL_LEN - 1);
  wire lock_lost  = lock_d_ff && !lock_indicator_pin;
  wire [2:0] ev   = {lock_lost, cal_done, release_ev};

  // lock indicator select
  logic ld_nxt;
  always_comb begin
    case (ld_mode)
      osec_pkg::OSEC_LD_FIRST:  ld_nxt = first_loop_locked;
      osec_pkg::OSEC_LD_SECOND: ld_nxt = second_loop_locked;
      default:                  ld_nxt = first_loop_locked && second_loop_locked;
    endcase
  end

  // automatic input switch: leave a lost input if the other is good
  wire sel_auto = sel_b_ff ? !(primary_ref_b_lost && !primary_ref_a_lost)
                           : (primary_ref_a_lost && !primary_ref_b_lost);
  wire sel_nxt  = cfg_ff[osec_pkg::CFG_AUTO_SEL] ? sel_auto
                                                 : cfg_ff[osec_pkg::CFG_MAN_SEL];

  // registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ch_en_ff  <= NUM_CH'(osec_pkg::CH_EN_RST);
      cfg_ff    <= osec_pkg::CFG_RST;
      fb_div_ff <= osec_pkg::FB_DIV_RST;
      irq_en_ff <= 3'h0;
    end else begin
      if (wr_ch)  ch_en_ff  <= reg_wdata[NUM_CH-1:0];
      if (wr_cfg) cfg_ff    <= reg_wdata;
      if (wr_fb)  fb_div_ff <= reg_wdata[17:0];
      if (wr_ien) irq_en_ff <= reg_wdata[2:0];
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) sts_ff <= 3'h0;
    else       sts_ff <= (sts_ff & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | ev;
  end

  // read data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      case (reg_addr)
        osec_pkg::ADDR_CH_EN:  reg_rdata <= 32'(ch_en_ff);
        osec_pkg::ADDR_CFG:    reg_rdata <= cfg_ff;
        osec_pkg::ADDR_FB_DIV: reg_rdata <= 32'(fb_div_ff);
        osec_pkg::ADDR_STATUS: reg_rdata <= {27'h0, hold_ff, vco_cal_busy, sts_ff};
        osec_pkg::ADDR_IRQ_EN: reg_rdata <= 32'(irq_en_ff);
        default:               reg_rdata <= 32'h0000_0000;
      endcase
    end else reg_rdata <= 32'h0000_0000;
  end

  // sync synchroniser and latency counters
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_m_ff <= 1'b1;
      sync_s_ff <= 1'b1;
      lo_cnt_ff <= 3'h0;
      hi_cnt_ff <= 3'h0;
      hold_ff   <= 1'b0;
    end else begin
      sync_m_ff <= sync_n;
      sync_s_ff <= sync_m_ff;
      if (!sync_s_ff && !hold_ff) begin
        lo_cnt_ff <= sync_lo_cnt_done ? 3'h0 : lo_cnt_ff + osec_pkg::LAT_W_ONE;
        if (sync_lo_cnt_done) hold_ff <= 1'b1;
      end else lo_cnt_ff <= 3'h0;
      if (hold_ff && sync_s_ff) begin
        hi_cnt_ff <= sync_hi_cnt_done ? 3'h0 : hi_cnt_ff + osec_pkg::LAT_W_ONE;
        if (sync_hi_cnt_done) hold_ff <= 1'b0;
      end else hi_cnt_ff <= 3'h0;
    end
  end

  // outputs: hold gates, enable gating, pin low forces low
  wire [NUM_CH-1:0] run = (global_output_enable_pin && !hold_ff) ? ch_clk_in : '0;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ch_out    <= '0;
      ch_out_oe <= '0;
    end else begin
      ch_out    <= run & ch_en_ff & {NUM_CH{g_en}};
      ch_out_oe <= ch_en_ff & {NUM_CH{g_en}};
    end
  end

  // calibration sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cal_req_ff   <= 1'b0;
      vco_cal_busy <= 1'b0;
      cal_cnt_ff   <= 8'h00;
    end else begin
      if (wr_fb) cal_req_ff <= 1'b1;
      else if (cal_start) cal_req_ff <= 1'b0;
      if (cal_start) begin
        vco_cal_busy <= 1'b1;
        cal_cnt_ff   <= 8'h00;
      end else if (cal_done) vco_cal_busy <= 1'b0;
      else if (vco_cal_busy) cal_cnt_ff <= cal_cnt_ff + 8'h01;
    end
  end

  // routing outputs and lock pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_indicator_pin     <= 1'b0;
      lock_d_ff              <= 1'b0;
      sel_b_ff               <= 1'b0;
      ref_sel_b              <= 1'b0;
      doubler_path_en        <= 1'b0;
      divider_path_en        <= 1'b1;                           // matches cfg reset
      first_loop_fb_src_en   <= 1'b0;
      second_loop_ref_src_en <= 1'b0;
      crystal_osc_en         <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      lock_indicator_pin     <= ld_nxt;
      lock_d_ff              <= lock_indicator_pin;
      sel_b_ff               <= sel_nxt;
      ref_sel_b              <= sel_nxt;
      doubler_path_en        <= cfg_ff[osec_pkg::CFG_DOUBLER];
      divider_path_en        <= !cfg_ff[osec_pkg::CFG_DOUBLER];
      first_loop_fb_src_en   <= 1'b1;
      second_loop_ref_src_en <= 1'b1;
      crystal_osc_en         <= cfg_ff[osec_pkg::CFG_XTAL_EN];
      irq                    <= |(sts_ff & irq_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  // synchroniser stages follow one another
  property p_sync_m;
    @(posedge clock) disable iff (!rstn) 1'b1 |=> sync_m_ff == $past(sync_n);
  endproperty
  a_sync_m: assert property (p_sync_m) else $error("first stage wrong");

  property p_sync_s;
    @(posedge clock) disable iff (!rstn) 1'b1 |=> sync_s_ff == $past(sync_m_ff);
  endproperty
  a_sync_s: assert property (p_sync_s) else $error("second stage wrong");

  // hold set after four synced low cycles
  property p_sync_hold;
    @(posedge clock) disable iff (!rstn)
    (!sync_s_ff && !hold_ff && lo_cnt_ff == 3'h0) ##1 (!sync_s_ff) [*3] |=> hold_ff;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("hold late");

  property p_lo_cnt;
    @(posedge clock) disable iff (!rstn) lo_cnt_ff <= 3'(osec_pkg::SYNC_LATENCY - 1);
  endproperty
  a_lo_cnt: assert property (p_lo_cnt) else $error("low count overrun");

  property p_hold_rise;
    @(posedge clock) disable iff (!rstn)
    $rose(hold_ff) |-> $past(lo_cnt_ff) == 3'(osec_pkg::SYNC_LATENCY - 1);
  endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("hold early");

  property p_hold_low;
    @(posedge clock) disable iff (!rstn) hold_ff |=> ch_out == '0;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("output not low");

  property p_hold_keep;
    @(posedge clock) disable iff (!rstn) hold_ff && !sync_s_ff |=> hold_ff;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold dropped");

  // release four cycles after synced high
  property p_release;
    @(posedge clock) disable iff (!rstn)
    $rose(sync_s_ff) && hold_ff |-> hold_ff [*4] ##1 !hold_ff;
  endproperty
  a_release: assert property (p_release) else $error("release timing");

  property p_hi_cnt;
    @(posedge clock) disable iff (!rstn) hi_cnt_ff <= 3'(osec_pkg::SYNC_LATENCY - 1);
  endproperty
  a_hi_cnt: assert property (p_hi_cnt) else $error("high count overrun");

  property p_hold_fall;
    @(posedge clock) disable iff (!rstn) $fell(hold_ff) |-> $past(sync_s_ff);
  endproperty
  a_hold_fall: assert property (p_hold_fall) else $error("release while low");

  property p_release_sts;
    @(posedge clock) disable iff (!rstn) release_ev |=> sts_ff[0];
  endproperty
  a_release_sts: assert property (p_release_sts) else $error("release not flagged");

  // running outputs follow the channel clocks together
  property p_run;
    @(posedge clock) disable iff (!rstn)
    global_output_enable_pin && !hold_ff && g_en |=> ch_out == $past(ch_clk_in & ch_en_ff);
  endproperty
  a_run: assert property (p_run) else $error("outputs not running");

  // enable gating
  property p_oe_follow;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> ch_out_oe == $past(ch_en_ff & {NUM_CH{g_en}});
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("enable not applied");

  property p_out_in_oe;
    @(posedge clock) disable iff (!rstn) (ch_out & ~ch_out_oe) == '0;
  endproperty
  a_out_in_oe: assert property (p_out_in_oe) else $error("output while off");

  property p_off;
    @(posedge clock) disable iff (!rstn) !g_en |=> ch_out_oe == '0;
  endproperty
  a_off: assert property (p_off) else $error("output not off");

  property p_goe_low;
    @(posedge clock) disable iff (!rstn) !global_output_enable_pin |=> ch_out == '0;
  endproperty
  a_goe_low: assert property (p_goe_low) else $error("pin low ignored");

  // reference routing
  property p_paths;
    @(posedge clock) disable iff (!rstn) doubler_path_en != divider_path_en;
  endproperty
  a_paths: assert property (p_paths) else $error("both paths");

  property p_doubler;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> doubler_path_en == $past(cfg_ff[osec_pkg::CFG_DOUBLER]);
  endproperty
  a_doubler: assert property (p_doubler) else $error("doubler path wrong");

  property p_src;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> first_loop_fb_src_en && second_loop_ref_src_en;
  endproperty
  a_src: assert property (p_src) else $error("reference not fanned out");

  property p_xtal;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> crystal_osc_en == $past(cfg_ff[osec_pkg::CFG_XTAL_EN]);
  endproperty
  a_xtal: assert property (p_xtal) else $error("oscillator enable wrong");

  property p_sel_manual;
    @(posedge clock) disable iff (!rstn)
    !cfg_ff[osec_pkg::CFG_AUTO_SEL] |=> ref_sel_b == $past(cfg_ff[osec_pkg::CFG_MAN_SEL]);
  endproperty
  a_sel_manual: assert property (p_sel_manual) else $error("manual select wrong");

  // calibration
  property p_cal_gate;
    @(posedge clock) disable iff (!rstn) $rose(vco_cal_busy) |-> $past(first_loop_locked);
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("cal without lock");

  property p_cal_idle;
    @(posedge clock) disable iff (!rstn)
    !first_loop_locked && !vco_cal_busy |=> !vco_cal_busy;
  endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("cal started unlocked");

  property p_cal_start;
    @(posedge clock) disable iff (!rstn) cal_start |=> vco_cal_busy;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("cal not started");

  property p_cal_req;
    @(posedge clock) disable iff (!rstn) wr_fb |=> cal_req_ff;
  endproperty
  a_cal_req: assert property (p_cal_req) else $error("cal not requested");

  // lock indicator modes
  property p_ld_both;
    @(posedge clock) disable iff (!rstn)
    ld_mode == 2'b00 |=> lock_indicator_pin == $past(first_loop_locked && second_loop_locked);
  endproperty
  a_ld_both: assert property (p_ld_both) else $error("lock pin wrong");

  property p_ld_first;
    @(posedge clock) disable iff (!rstn)
    ld_mode == 2'b01 |=> lock_indicator_pin == $past(first_loop_locked);
  endproperty
  a_ld_first: assert property (p_ld_first) else $error("first lock wrong");

  property p_ld_second;
    @(posedge clock) disable iff (!rstn)
    ld_mode == 2'b10 |=> lock_indicator_pin == $past(second_loop_locked);
  endproperty
  a_ld_second: assert property (p_ld_second) else $error("second lock wrong");

  // main scenarios
  c_hold_set: cover property (@(posedge clock) disable iff (!rstn) $rose(hold_ff));
  c_hold: cover property (@(posedge clock) disable iff (!rstn) $fell(hold_ff));
  c_goe: cover property (@(posedge clock) disable iff (!rstn) !global_output_enable_pin && g_en);
  c_cal: cover property (@(posedge clock) disable iff (!rstn) cal_done);
  c_irq: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
endmodule

// ===== tb/osec_board.sv
`timescale 1ns/1ns
// board side: sync pin and output-enable pin
module osec_board (
  // clock
  input  wire logic clock,
  // bench controls
  input  wire logic sync_req,
  input  wire logic oe_drive,
  input  wire logic oe_level,
  // pins
  output logic      sync_n,
  output logic      oe_pin
);
  logic [1:0] low_cnt_ff = 2'h0;

  // keep sync low for three more cycles after every sync request
  always @(posedge clock) begin
    if (sync_req)
      low_cnt_ff <= 2'h3;
    else if (low_cnt_ff != 2'h0)
      low_cnt_ff <= low_cnt_ff - 2'h1;
  end
  assign sync_n = !(sync_req || low_cnt_ff != 2'h0);
  assign oe_pin = oe_drive ? oe_level : 1'b1;        // pull-up when undriven
endmodule

// ===== tb/osec_top_tb.sv
`timescale 1ns/1ns
module osec_top_tb;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        sync_req = 1'b0;
  logic        oe_drive = 1'b0;
  logic        sync_n;
  logic        oe_pin;
  logic        first_loop_locked = 1'b0;
  logic        second_loop_locked = 1'b0;
  logic        primary_ref_a_lost = 1'b0;
  logic        primary_ref_b_lost = 1'b0;
  logic        clk_run = 1'b0;
  logic [4:0]  ch_clk_in = 5'h1f;
  logic [4:0]  ch_out;
  logic [4:0]  ch_out_oe;
  logic [4:0]  route;
  logic        lock_indicator_pin;
  logic        ref_sel_b;
  logic        vco_cal_busy;
  logic        irq;
  int          num_errors = 0;
  int          checked = 0;
  int          first;

  //////////////////////////////////////////////////////////////////////////////
  // clock, channel clocks, board and design
  always #2 clock = ~clock;
  always @(posedge clock) if (clk_run) ch_clk_in <= ~ch_clk_in;
  osec_board board (.clock, .sync_req, .oe_drive, .oe_level(1'b0), .sync_n, .oe_pin);
  osec_top #(.NUM_CH(5), .CAL_LEN(8)) dut (
    .clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sync_n,
    .global_output_enable_pin(oe_pin), .first_loop_locked, .second_loop_locked,
    .primary_ref_a_lost, .primary_ref_b_lost, .ch_clk_in, .ch_out, .ch_out_oe,
    .lock_indicator_pin, .ref_sel_b, .doubler_path_en(route[4]),
    .divider_path_en(route[3]), .crystal_osc_en(route[2]),
    .first_loop_fb_src_en(route[1]), .second_loop_ref_src_en(route[0]),
    .vco_cal_busy, .irq);

  //////////////////////////////////////////////////////////////////////////////
  // access and compare tasks
  task automatic at(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hffff_ffff);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic gate(input logic [4:0] en, input logic [31:0] cfg, input logic drv,
                      input logic [9:0] e);
    wr(osec_pkg::ADDR_CH_EN, {27'h0, en});
    wr(osec_pkg::ADDR_CFG, cfg);
    oe_drive <= drv;
    at(4);
    chk({ch_out_oe, ch_out & ch_out_oe}, e);
  endtask
  task automatic refc(input logic [31:0] cfg, input logic la, input logic lb);
    wr(osec_pkg::ADDR_CFG, cfg);
    primary_ref_a_lost <= la;
    primary_ref_b_lost <= lb;
    at(4);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #20000;
    num_errors++;
    $display("MISMATCH %0t watchdog", $time);
    report_and_stop;
  end

  //////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    at(3);
    rstn <= 1'b1;
    at(2);
    rdchk(osec_pkg::ADDR_CH_EN, 32'h0000_001f);
    rdchk(osec_pkg::ADDR_CFG, 32'h0000_0001);
    rdchk(4'h6, 32'h0000_0000);
    rdchk(osec_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
    $display("test regs done");
    gate(5'h1f, 32'h0000_0001, 1'b0, 10'h3ff);
    gate(5'h1f, 32'h0000_0001, 1'b1, 10'h3e0);
    gate(5'h1f, 32'h0000_0000, 1'b0, 10'h000);
    gate(5'h05, 32'h0000_0001, 1'b0, 10'h0a5);
    wr(osec_pkg::ADDR_CH_EN, 32'h0000_001f);
    $display("test gate done");
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        wr(osec_pkg::ADDR_CFG, 32'h0000_0001 | 32'(m << osec_pkg::CFG_LD_LO));
        {first_loop_locked, second_loop_locked} <= 2'(k);
        at(3);
        chk(lock_indicator_pin, m == 0 ? k == 3 : (m == 1 ? k[1] : k[0]));
      end
    end
    $display("test lock done");
    wr(osec_pkg::ADDR_CFG, 32'h0000_0007);
    at(2);
    chk(route, 5'b10111);
    refc(32'h0000_0011, 1'b0, 1'b0);
    chk(ref_sel_b, 1'b1);
    chk(route, 5'b01011);
    refc(32'h0000_0001, 1'b0, 1'b0);
    chk(ref_sel_b, 1'b0);
    refc(32'h0000_0009, 1'b1, 1'b0);
    chk(ref_sel_b, 1'b1);
    refc(32'h0000_0009, 1'b0, 1'b1);
    chk(ref_sel_b, 1'b0);
    refc(32'h0000_0009, 1'b1, 1'b1);
    chk(ref_sel_b, 1'b0);
    refc(32'h0000_0001, 1'b0, 1'b0);
    $display("test route done");
    wr(osec_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    clk_run <= 1'b1;
    at(4);
    sync_req <= 1'b1;
    first = 0;
    for (int i = 1; i <= 12; i++) begin
      at(1);
      if ((i == 4 || i == 5) && ch_out != 5'h00) first = 1;
      if (i >= 9) chk(ch_out, 5'h00);
    end
    chk(first, 1);
    sync_req <= 1'b0;
    first = 0;
    for (int i = 1; i <= 12; i++) begin
      at(1);
      if (first == 0 && ch_out != 5'h00) first = i;
      chk(ch_out == 5'h00 || ch_out == 5'h1f, 1'b1);
    end
    chk(first >= 10 && first <= 11, 1'b1);
    chk(irq, 1'b1);
    rdchk(osec_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(osec_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    at(2);
    chk(irq, 1'b0);
    wr(osec_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    wr(osec_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    at(2);
    chk(irq, 1'b0);
    $display("test sync done");
    first_loop_locked <= 1'b0;
    at(14);
    wr(osec_pkg::ADDR_FB_DIV, 32'h0000_0010);
    at(6);
    chk(vco_cal_busy, 1'b0);
    rdchk(osec_pkg::ADDR_FB_DIV, 32'h0000_0010);
    first_loop_locked <= 1'b1;
    at(3);
    chk(vco_cal_busy, 1'b1);
    at(10);
    chk(vco_cal_busy, 1'b0);
    rdchk(osec_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
    wr(osec_pkg::ADDR_FB_DIV, 32'h0000_0011);
    at(3);
    chk(vco_cal_busy, 1'b1);
    $display("test cal done");
    report_and_stop;
  end
endmodule
